// ---- nbh_defines.vh ----
// Constants for the NAND bus host controller.
// Assumes a 125 MHz system clock; all pin timing is counted in its cycles.
`ifndef NBH_DEFINES_VH
`define NBH_DEFINES_VH

// ****************************************
// Command codes
// ****************************************
`define NBH_CMD_READ        8'h00
`define NBH_CMD_RESET       8'hFF
`define NBH_CMD_STATUS      8'h70

// ****************************************
// Operation kinds from the user port
// ****************************************
`define NBH_OP_CMD          2'h0
`define NBH_OP_ADDR         2'h1
`define NBH_OP_DIN          2'h2
`define NBH_OP_WAIT         2'h3

// ****************************************
// Timing, address and sequence limits
// ****************************************
`define NBH_CLK_MHZ         125
`define NBH_STROBE_NS       40
`define NBH_STROBE_CYC      ((`NBH_STROBE_NS * `NBH_CLK_MHZ + 999) / 1000)
`define NBH_PROG_MAX_US     600
`define NBH_PROT_MAX_US     800
`define NBH_TIMEOUT_CYC     (`NBH_PROT_MAX_US * `NBH_CLK_MHZ)
`define NBH_ADDR_CYCLES     3'h4
`define NBH_ADDR_BITS       27
`define NBH_SLOT_MAX        3'h4
`define NBH_MAIN_SEG        10'h200
`define NBH_SPARE_SEG       6'h20
`define NBH_SMALL_MIN       10'h004

`endif

// ---- nbh_host.v ----
// NAND bus host: turns queued bus operations into command, address and data-in cycles.
// Assumes the memory's ready/busy pin arrives synchronous to i_clock, pulled high.
`include "nbh_defines.vh"

module nbh_host #(
    parameter STROBE_CYC  = `NBH_STROBE_CYC,
    parameter TIMEOUT_CYC = `NBH_TIMEOUT_CYC
) (
    input  wire        i_clock,
    input  wire        i_rst_n,
    input  wire        i_op_valid,
    input  wire [1:0]  i_op_kind,
    input  wire [7:0]  i_op_data,
    output reg         o_op_ready,
    input  wire        i_ready_busy,
    output reg         o_chip_select_n,
    output reg         o_cmd_latch,
    output reg         o_addr_latch,
    output reg         o_write_strobe_n,
    output reg         o_read_strobe_n,
    output reg         o_write_protect_n,
    output reg  [7:0]  o_io_out,
    output reg         o_io_oe,
    output reg         o_init_done,
    output reg         o_wait_done,
    output reg         o_timeout,
    output reg         o_seq_error
);

    // ****************************************
    // States
    // ****************************************
    localparam [5:0] ST_BOOT  = 6'h01;
    localparam [5:0] ST_IDLE  = 6'h02;
    localparam [5:0] ST_SETUP = 6'h04;
    localparam [5:0] ST_LOW   = 6'h08;
    localparam [5:0] ST_HIGH  = 6'h10;
    localparam [5:0] ST_WAIT  = 6'h20;

    reg  [5:0]  state;
    reg  [5:0]  next_state;
    reg  [15:0] tick;
    reg  [19:0] busy_cnt;
    reg  [2:0]  addr_cnt;
    reg         boot_sent;

    // ****************************************
    // Two-entry skid buffer on the op path
    // ****************************************
    // Two words let o_op_ready come from a flop without losing a word on stall.
    reg  [9:0]  buf_word0;
    reg  [9:0]  buf_word1;
    reg  [1:0]  buf_count;
    wire        buf_valid = (buf_count != 2'h0);
    wire        buf_pop;
    wire        buf_push  = i_op_valid && o_op_ready;
    wire [1:0]  head_kind = buf_word0[9:8];
    wire [7:0]  head_data = buf_word0[7:0];

    function is_modify;
        input [7:0] code;
        begin
            is_modify = (code == 8'h80) || (code == 8'h81) || (code == 8'h85)
                     || (code == 8'h60) || (code == 8'h10) || (code == 8'h11)
                     || (code == 8'hD0) || (code == 8'hEF);
        end
    endfunction

    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            buf_count  <= 2'h0;
            buf_word0  <= 10'h000;
            buf_word1  <= 10'h000;
            o_op_ready <= 1'b0;
        end else begin
            case ({buf_push, buf_pop})
                2'b10: begin
                    if (buf_count == 2'h0)
                        buf_word0 <= {i_op_kind, i_op_data};
                    else
                        buf_word1 <= {i_op_kind, i_op_data};
                    buf_count <= buf_count + 2'h1;
                end
                2'b01: begin
                    buf_word0 <= buf_word1;
                    buf_count <= buf_count - 2'h1;
                end
                2'b11: begin
                    if (buf_count == 2'h1)
                        buf_word0 <= {i_op_kind, i_op_data};
                    else begin
                        buf_word0 <= buf_word1;
                        buf_word1 <= {i_op_kind, i_op_data};
                    end
                end
                default: begin
                    buf_count <= buf_count;
                end
            endcase
            o_op_ready <= (buf_count == 2'h0) || (buf_count == 2'h1 && !buf_push)
                       || (buf_count == 2'h1 && buf_pop);
        end
    end

    assign buf_pop = (state == ST_IDLE) && buf_valid && o_init_done;

    // ****************************************
    // Command sequence monitor
    // ****************************************
    // Slips are only flagged on o_seq_error; the op still goes out as queued.
    reg         mp_open;
    reg         status_seen;
    reg         col_check;
    reg         col_only;
    reg         cb_pend;
    reg         src_odd;
    reg  [2:0]  prog_cnt;
    reg  [9:0]  din_cnt;
    reg  [15:0] row_work;
    reg  [15:0] last_row;
    reg         mon_err;
    wire        same_row = (row_work == last_row);
    wire        pop_cmd  = buf_pop && (head_kind == `NBH_OP_CMD);
    wire        pop_addr = buf_pop && (head_kind == `NBH_OP_ADDR);
    wire        pop_din  = buf_pop && (head_kind == `NBH_OP_DIN);
    function mp_allowed;
        input [7:0] code;
        begin
            mp_allowed = (code == 8'h81) || (code == `NBH_CMD_STATUS) || (code == 8'h78)
                      || (code == `NBH_CMD_RESET);
        end
    endfunction
    always @* begin
        mon_err = 1'b0;
        if (pop_cmd) begin
            if (mp_open && !mp_allowed(head_data))
                mon_err = 1'b1;
            if ((head_data == 8'h85 || head_data == 8'h10 || head_data == 8'h11)
                && din_cnt != 10'h000 && din_cnt < `NBH_SMALL_MIN)
                mon_err = 1'b1;
            if (head_data == 8'h10 && ((same_row && prog_cnt >= `NBH_SLOT_MAX)
                || (cb_pend && row_work[0] != src_odd)))
                mon_err = 1'b1;
            if (head_data == 8'h05 && status_seen)
                mon_err = 1'b1;
        end
        if (pop_addr && col_check && addr_cnt == 3'h0 && head_data[1:0] != 2'h0)
            mon_err = 1'b1;
        if (pop_din && same_row && prog_cnt != 3'h0 && din_cnt == `NBH_MAIN_SEG)
            mon_err = 1'b1;
    end
    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            mp_open     <= 1'b0;
            status_seen <= 1'b0;
            col_check   <= 1'b0;
            col_only    <= 1'b0;
            cb_pend     <= 1'b0;
            prog_cnt    <= 3'h0;
            din_cnt     <= 10'h000;
            row_work    <= 16'h0000;
            last_row    <= 16'h0000;
        end else begin
            if (pop_cmd) begin
                col_check <= (head_data == 8'h80) || (head_data == 8'h81) || (head_data == 8'h85);
                case (head_data)
                    8'h80, 8'h81: begin
                        mp_open  <= 1'b0;
                        col_only <= 1'b0;
                        din_cnt  <= 10'h000;
                    end
                    8'h85: begin
                        col_only <= 1'b1;
                        din_cnt  <= 10'h000;
                    end
                    8'h10: begin
                        prog_cnt <= same_row ? prog_cnt + {2'h0, prog_cnt != 3'h7} : 3'h1;
                        last_row <= row_work;
                        mp_open  <= 1'b0;
                        cb_pend  <= 1'b0;
                        din_cnt  <= 10'h000;
                    end
                    8'h11:           mp_open     <= 1'b1;
                    8'h35: begin
                        cb_pend <= 1'b1;
                        src_odd <= row_work[0];
                    end
                    8'hD0:           prog_cnt    <= 3'h0; // Any erase restarts the count, coarse
                    `NBH_CMD_STATUS: status_seen <= 1'b1;
                    `NBH_CMD_READ:   status_seen <= 1'b0;
                    `NBH_CMD_RESET:  mp_open     <= 1'b0;
                    default:         din_cnt     <= din_cnt;
                endcase
            end
            if (pop_addr && addr_cnt == 3'h2)
                row_work[7:0] <= head_data;
            if (pop_addr && addr_cnt == 3'h3)
                row_work[15:8] <= head_data;
            if (pop_din && din_cnt != 10'h3FF)
                din_cnt <= din_cnt + 10'h001;
        end
    end

    // ****************************************
    // Bus cycle sequencer
    // ****************************************
    always @* begin
        next_state = state;
        case (state)
            ST_BOOT:  next_state = i_ready_busy ? ST_SETUP : ST_BOOT;
            ST_IDLE:  next_state = buf_pop ? ((head_kind == `NBH_OP_WAIT) ? ST_WAIT : ST_SETUP)
                                           : ST_IDLE;
            ST_SETUP: next_state = (tick == 16'h0000) ? ST_LOW : ST_SETUP;
            ST_LOW:   next_state = (tick == 16'h0000) ? ST_HIGH : ST_LOW;
            ST_HIGH:  next_state = (tick == 16'h0000) ? ST_IDLE : ST_HIGH;
            ST_WAIT:  next_state = (i_ready_busy && busy_cnt != 20'h00000) ? ST_IDLE
                                 : ((busy_cnt >= TIMEOUT_CYC[19:0]) ? ST_IDLE : ST_WAIT);
            default:  next_state = ST_IDLE;
        endcase
    end

    always @(posedge i_clock) begin
        if (!i_rst_n) begin
            state             <= ST_BOOT;
            tick              <= 16'h0000;
            busy_cnt          <= 20'h00000;
            addr_cnt          <= 3'h0;
            boot_sent         <= 1'b0;
            o_chip_select_n   <= 1'b1;
            o_cmd_latch       <= 1'b0;
            o_addr_latch      <= 1'b0;
            o_write_strobe_n  <= 1'b1;
            o_read_strobe_n   <= 1'b1;
            o_write_protect_n <= 1'b0;
            o_io_out          <= 8'h00;
            o_io_oe           <= 1'b0;
            o_init_done       <= 1'b0;
            o_wait_done       <= 1'b0;
            o_timeout         <= 1'b0;
            o_seq_error       <= 1'b0;
        end else begin
            state       <= next_state;
            o_wait_done <= 1'b0;
            o_timeout   <= 1'b0;
            o_seq_error <= mon_err;
            if (tick != 16'h0000)
                tick <= tick - 16'h0001;
            case (state)
                ST_BOOT: begin
                    if (i_ready_busy) begin
                        o_chip_select_n <= 1'b0;
                        o_cmd_latch     <= 1'b1;
                        o_io_out        <= `NBH_CMD_RESET;
                        o_io_oe         <= 1'b1;
                        boot_sent       <= 1'b1;
                        tick            <= STROBE_CYC[15:0];
                    end
                end
                ST_IDLE: begin
                    o_io_oe         <= 1'b0;
                    o_cmd_latch     <= 1'b0;
                    o_addr_latch    <= 1'b0;
                    if (boot_sent) begin
                        boot_sent <= 1'b0;
                        o_init_done <= 1'b1;
                    end
                    if (buf_pop) begin
                        o_chip_select_n <= 1'b0;
                        o_read_strobe_n <= 1'b1;
                        tick            <= STROBE_CYC[15:0];
                        busy_cnt        <= 20'h00000;
                        case (head_kind)
                            `NBH_OP_CMD: begin
                                o_cmd_latch <= 1'b1;
                                o_io_out    <= head_data;
                                o_io_oe     <= 1'b1;
                                addr_cnt    <= 3'h0;
                                if (is_modify(head_data))
                                    o_write_protect_n <= 1'b1;
                            end
                            `NBH_OP_ADDR: begin
                                o_addr_latch <= 1'b1;
                                o_io_out     <= head_data;
                                o_io_oe      <= 1'b1;
                                addr_cnt     <= addr_cnt + 3'h1;
                            end
                            `NBH_OP_DIN: begin
                                o_io_out <= head_data;
                                o_io_oe  <= 1'b1;
                                if (addr_cnt != 3'h0
                                    && addr_cnt < (col_only ? 3'h2 : `NBH_ADDR_CYCLES))
                                    o_seq_error <= 1'b1;
                            end
                            default: begin
                                o_io_oe <= 1'b0;
                            end
                        endcase
                    end else begin
                        o_chip_select_n <= 1'b1;
                    end
                end
                ST_SETUP: begin
                    if (tick == 16'h0000) begin
                        o_write_strobe_n <= 1'b0;
                        tick             <= STROBE_CYC[15:0];
                    end
                end
                ST_LOW: begin
                    if (tick == 16'h0000) begin
                        // Rising edge latches the byte in the memory
                        o_write_strobe_n <= 1'b1;
                        tick             <= STROBE_CYC[15:0];
                    end
                end
                ST_HIGH: begin
                    if (tick == 16'h0000) begin
                        o_cmd_latch  <= 1'b0;
                        o_addr_latch <= 1'b0;
                        o_io_oe      <= 1'b0;
                    end
                end
                ST_WAIT: begin
                    // Bound covers the longest busy, protected-area programming
                    busy_cnt <= busy_cnt + 20'h00001;
                    if (i_ready_busy && busy_cnt != 20'h00000) begin
                        o_wait_done       <= 1'b1;
                        o_write_protect_n <= 1'b0;
                    end else if (busy_cnt >= TIMEOUT_CYC[19:0]) begin
                        o_timeout         <= 1'b1;
                        o_write_protect_n <= 1'b0;
                    end
                end
                default: begin
                    o_chip_select_n <= 1'b1;
                end
            endcase
        end
    end

endmodule

// ---- nbh_host_sva.sv ----
// Checker for the nbh_host pin side.
// Assumes STROBE_CYC of 5, so each strobe is low for six cycles.
module nbh_host_sva (
    input wire       i_clock,
    input wire       i_rst_n,
    input wire       i_ready_busy,
    input wire       o_chip_select_n,
    input wire       o_cmd_latch,
    input wire       o_addr_latch,
    input wire       o_write_strobe_n,
    input wire       o_read_strobe_n,
    input wire       o_write_protect_n,
    input wire [7:0] o_io_out,
    input wire       o_io_oe,
    input wire       o_wait_done,
    input wire       o_timeout
);
    // ****************************************
    // Pin relations
    // ****************************************
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    a_strobe_needs_cs: assert property (!o_write_strobe_n |-> !o_chip_select_n)
        else $error("strobe with chip select high");
    a_one_latch_only: assert property (!(o_cmd_latch && o_addr_latch))
        else $error("both latch enables high");
    a_read_strobe_idle: assert property (o_read_strobe_n)
        else $error("read strobe active");
    a_strobe_low_width: assert property ($fell(o_write_strobe_n) |=>
        !o_write_strobe_n [*5] ##1 o_write_strobe_n) else $error("strobe width wrong");
    a_bus_driven_low: assert property (!o_write_strobe_n |-> o_io_oe)
        else $error("bus not driven in strobe");
    a_hold_at_rise: assert property ($rose(o_write_strobe_n) |-> !o_chip_select_n &&
        $stable({o_io_out, o_cmd_latch, o_addr_latch})) else $error("bus moved at rise");
    a_hold_after_rise: assert property ($rose(o_write_strobe_n) |=>
        ($stable({o_io_out, o_cmd_latch, o_addr_latch}) && o_io_oe) [*4])
        else $error("bus not held after rise");
    a_protect_on_modify: assert property ($rose(o_write_strobe_n) && o_cmd_latch &&
        o_io_out == 8'h80 |-> o_write_protect_n) else $error("protect low on program");
    a_done_after_ready: assert property (o_wait_done |-> $past(i_ready_busy))
        else $error("done while busy");
    a_timeout_when_busy: assert property (o_timeout |-> !$past(i_ready_busy))
        else $error("timeout while ready");
endmodule

bind nbh_host nbh_host_sva i_nbh_host_sva (.i_clock, .i_rst_n, .i_ready_busy, .o_chip_select_n,
    .o_cmd_latch, .o_addr_latch, .o_write_strobe_n, .o_read_strobe_n, .o_write_protect_n,
    .o_io_out, .o_io_oe, .o_wait_done, .o_timeout);

// ---- nbh_flash_model.sv ----
// Behavioural flash on the far side of nbh_host; busy times in scaled cycles.
// Assumes pins are sampled on the host clock; reports each latched byte.
module nbh_flash_model #(
    parameter int PROG = 60,
    parameter int DBSY = 8,
    parameter int SLOW = 160
) (
    input  wire logic       i_clock,
    input  wire logic       i_rst_n,
    input  wire logic       i_slow,
    input  wire logic       i_cs_n,
    input  wire logic       i_cle,
    input  wire logic       i_ale,
    input  wire logic       i_we_n,
    input  wire logic       i_re_n,
    input  wire logic       i_wp_n,
    input  wire logic [7:0] i_io,
    output wire logic       o_ready_busy,
    output logic            o_cap_valid,
    output logic      [1:0] o_cap_kind,
    output logic      [7:0] o_cap_byte
);
    // ****************************************
    // Latch on strobe rise
    // ****************************************
    logic       we_q;
    logic [8:0] busy;
    wire take = !we_q && i_we_n && !i_cs_n && i_re_n && !(i_cle && i_ale)
        && (i_cle || i_ale || i_wp_n);
    always @(posedge i_clock) begin
        we_q <= i_we_n;
        o_cap_valid <= 1'b0;
        if (!i_rst_n) begin
            busy <= 9'h000;
        end else if (take) begin
            o_cap_valid <= 1'b1;
            o_cap_kind <= i_cle ? 2'h0 : (i_ale ? 2'h1 : 2'h2);
            o_cap_byte <= i_io;
            // Slow answer stands for protection area programming
            if (i_cle && i_io == 8'h10) busy <= i_slow ? 9'(SLOW) : 9'(PROG);
            if (i_cle && i_io == 8'h11) busy <= 9'(DBSY);
        end else if (busy != 9'h000) begin
            busy <= busy - 9'h001;
        end
    end
    assign o_ready_busy = (busy == 9'h000);
endmodule

// ---- nbh_host_test.sv ----
// Bench for nbh_host: random program traffic against a behavioural flash.
// Assumes the flash model counts busy in clock cycles, scaled down.
`include "nbh_defines.vh"
module nbh_host_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PROG = 60;
    localparam int DBSY = 8;
    logic       i_clock = 1'b0;
    logic       i_rst_n = 1'b0;
    logic       i_op_valid = 1'b0;
    logic [1:0] i_op_kind = 2'h0;
    logic [7:0] i_op_data = 8'h00;
    logic       slow = 1'b0;
    logic       ign = 1'b0;
    logic       stall_seen = 1'b0;
    logic       err_seen = 1'b0;
    wire        rdy, rb, cs_n, cle, ale, we_n, re_n, wp_n, oe, init_done, wait_done, tmo, err;
    wire  [7:0] io_out;
    wire        cap_valid;
    wire  [1:0] cap_kind;
    wire  [7:0] cap_byte;
    logic [9:0] exp_q[$];
    int         bad_count = 0;
    int         num_checks = 0;
    int         c;
    bit         dn;
    always #4 i_clock = ~i_clock;
    nbh_host #(.STROBE_CYC(5), .TIMEOUT_CYC(100)) i_nbh_host (.i_clock(i_clock),
        .i_rst_n(i_rst_n), .i_op_valid(i_op_valid), .i_op_kind(i_op_kind), .i_op_data(i_op_data),
        .o_op_ready(rdy), .i_ready_busy(rb), .o_chip_select_n(cs_n), .o_cmd_latch(cle),
        .o_addr_latch(ale), .o_write_strobe_n(we_n), .o_read_strobe_n(re_n),
        .o_write_protect_n(wp_n), .o_io_out(io_out), .o_io_oe(oe), .o_init_done(init_done),
        .o_wait_done(wait_done), .o_timeout(tmo), .o_seq_error(err));
    // Released bus shows the inverse so a stale byte cannot match
    nbh_flash_model i_nbh_flash_model (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_slow(slow),
        .i_cs_n(cs_n), .i_cle(cle), .i_ale(ale), .i_we_n(we_n), .i_re_n(re_n), .i_wp_n(wp_n),
        .i_io(oe ? io_out : ~io_out), .o_ready_busy(rb), .o_cap_valid(cap_valid),
        .o_cap_kind(cap_kind), .o_cap_byte(cap_byte));
    // ****************************************
    // Checks and tasks
    // ****************************************
    task automatic check(input bit ok, input string msg);
        num_checks++;
        if (!ok) begin
            bad_count++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask
    task automatic summarize();
        if (bad_count == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge i_clock) begin
        if (i_op_valid && rdy === 1'b0 && i_rst_n) stall_seen <= 1'b1;
        if (err === 1'b1) err_seen <= 1'b1;
        if (cap_valid === 1'b1 && exp_q.size() != 0) begin
            check({cap_kind, cap_byte} === exp_q[0], "bus byte differs");
            void'(exp_q.pop_front());
        end else if (cap_valid === 1'b1 && !ign) begin
            check(1'b0, "unexpected bus byte");
        end
    end
    task automatic push(input logic [1:0] k, input logic [7:0] d);
        int n;
        n = 0;
        i_op_valid <= 1'b1;
        i_op_kind <= k;
        i_op_data <= d;
        if (k != `NBH_OP_WAIT) exp_q.push_back({k, d});
        do begin
            @(posedge i_clock);
            n++;
        end while (rdy !== 1'b1 && n < 3000);
        if (n >= 3000) begin bad_count++; summarize(); end
    endtask
    task automatic prog(input logic [7:0] first, input logic [7:0] last, input int n);
        push(`NBH_OP_CMD, first);
        push(`NBH_OP_ADDR, 8'($urandom) & 8'hFC);
        push(`NBH_OP_ADDR, 8'($urandom));
        push(`NBH_OP_ADDR, 8'($urandom));
        push(`NBH_OP_ADDR, 8'($urandom) & 8'h07);
        for (int i = 0; i < n; i++) push(`NBH_OP_DIN, 8'($urandom));
        push(`NBH_OP_CMD, last);
    endtask
    task automatic wait_op(output bit done, output int cyc);
        push(`NBH_OP_WAIT, 8'h00);
        i_op_valid <= 1'b0;
        cyc = 0;
        while (wait_done !== 1'b1 && tmo !== 1'b1 && cyc < 3000) begin
            @(posedge i_clock);
            cyc++;
        end
        done = (wait_done === 1'b1);
        if (cyc >= 3000) begin bad_count++; summarize(); end
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        c = $urandom(45);
        exp_q.push_back({`NBH_OP_CMD, `NBH_CMD_RESET});
        repeat (4) @(posedge i_clock);
        i_rst_n <= 1'b1;
        c = 0;
        while (init_done !== 1'b1 && c < 500) begin @(posedge i_clock); c++; end
        check(init_done === 1'b1, "no boot reset");
        prog(8'h80, 8'h10, 4 + $urandom % 12);
        wait_op(dn, c);
        check(dn && c >= PROG && c <= PROG + 40, "program busy");
        repeat (2) @(posedge i_clock);
        check(wp_n === 1'b0, "protect left high");
        prog(8'h80, 8'h11, 4);
        wait_op(dn, c);
        check(dn && c >= DBSY && c <= DBSY + 40, "dummy busy");
        prog(8'h81, 8'h10, 8);
        wait_op(dn, c);
        check(dn && c >= PROG, "multiplane busy");
        slow <= 1'b1;
        prog(8'h80, 8'h10, 4);
        wait_op(dn, c);
        check(!dn && c >= 100, "no timeout");
        slow <= 1'b0;
        wait_op(dn, c);
        check(dn, "slow program end");
        check(stall_seen && exp_q.size() == 0, "buffer lost word");
        check(!err_seen, "false sequence error");
        ign = 1'b1;
        push(`NBH_OP_CMD, 8'h80);
        push(`NBH_OP_ADDR, 8'h00);
        push(`NBH_OP_DIN, 8'h5A);
        i_op_valid <= 1'b0;
        repeat (60) @(posedge i_clock);
        check(err_seen, "short address kept");
        summarize();
    end
endmodule
